/* File: src/dbw_pkg.sv */
// constants for the dead-band and auto-shutdown waveform block
package dbw_pkg;
  // ==========================================================================
  // bus shape
  localparam int          DATA_W      = 32;
  localparam int          ADDR_W      = 8;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // ==========================================================================
  // register byte offsets
  localparam logic [7:0]  OFF_CTRL    = 8'h00;
  localparam logic [7:0]  OFF_SHUT    = 8'h04;
  localparam logic [7:0]  OFF_FAULT   = 8'h08;
  localparam logic [7:0]  OFF_RISE    = 8'h0c;
  localparam logic [7:0]  OFF_FALL    = 8'h10;
  localparam logic [7:0]  OFF_CLK     = 8'h14;
  localparam logic [7:0]  OFF_STAT    = 8'h18;
  // ==========================================================================
  // field positions
  localparam int          EN_BIT      = 7;
  localparam int          LD_BIT      = 6;
  localparam int          MODE_LSB    = 0;
  localparam int          SD_BIT      = 7;
  localparam int          REN_BIT     = 6;
  localparam int          OVR_BD_LSB  = 4;
  localparam int          OVR_AC_LSB  = 2;
  localparam int          CS_BIT      = 0;
  localparam int          OVR_HI_BIT  = 1;
  // ==========================================================================
  // widths, codes and reset values
  localparam int          CNT_W       = 6;
  localparam int          MODE_W      = 3;
  localparam int          FAULT_N     = 4;
  localparam int          SYNC_W      = FAULT_N + 2;
  localparam logic [2:0]  MODE_HALF   = 3'h4;
  localparam logic [2:0]  MODE_FWD    = 3'h2;
  localparam logic [2:0]  MODE_REV    = 3'h3;
  localparam logic [1:0]  OVR_RST     = 2'h1;
  localparam logic [5:0]  SYNC_RST    = 6'h1e;
  localparam logic [5:0]  CNT_ONE     = 6'h01;
  localparam logic [5:0]  CNT_ZERO    = 6'h00;
endpackage

/* File: src/dbw_top.sv */
// dead-band timing and auto-shutdown waveform block with axi4-lite registers

module dbw_top (
  // clock and reset
  input  wire logic                          i_mclk,
  input  wire logic                          i_rst_b,
  // axi4-lite write address
  input  wire logic                          i_s_awvalid,
  output      logic                          o_s_awready,
  input  wire logic [dbw_pkg::ADDR_W-1:0]    i_s_awaddr,
  input  wire logic [2:0]                    i_s_awprot,
  // axi4-lite write data
  input  wire logic                          i_s_wvalid,
  output      logic                          o_s_wready,
  input  wire logic [dbw_pkg::DATA_W-1:0]    i_s_wdata,
  input  wire logic [3:0]                    i_s_wstrb,
  // axi4-lite write response
  output      logic                          o_s_bvalid,
  input  wire logic                          i_s_bready,
  output      logic [1:0]                    o_s_bresp,
  // axi4-lite read
  input  wire logic                          i_s_arvalid,
  output      logic                          o_s_arready,
  input  wire logic [dbw_pkg::ADDR_W-1:0]    i_s_araddr,
  input  wire logic [2:0]                    i_s_arprot,
  output      logic                          o_s_rvalid,
  input  wire logic                          i_s_rready,
  output      logic [dbw_pkg::DATA_W-1:0]    o_s_rdata,
  output      logic [1:0]                    o_s_rresp,
  // data, fault and oscillator inputs, asynchronous
  input  wire logic                          i_data,
  input  wire logic [dbw_pkg::FAULT_N-1:0]   i_fault_b,
  input  wire logic                          i_fast_osc,
  // bridge outputs and status
  output      logic                          o_out_a,
  output      logic                          o_out_b,
  output      logic                          o_out_c,
  output      logic                          o_out_d,
  output      logic                          o_shutdown_event,
  output      logic                          o_fast_osc_keep
);
  // ==========================================================================
  // registers
  logic                        en;
  logic                        load_request;
  logic [dbw_pkg::MODE_W-1:0]  mode;
  logic                        shutdown;
  logic                        restart_en;
  logic [1:0]                  override_level_bd;
  logic [1:0]                  override_level_ac;
  logic [dbw_pkg::FAULT_N-1:0] fault_source_enable;
  logic [dbw_pkg::CNT_W-1:0]   rise_buf;
  logic [dbw_pkg::CNT_W-1:0]   fall_buf;
  logic [dbw_pkg::CNT_W-1:0]   rise_deadband_count;
  logic [dbw_pkg::CNT_W-1:0]   fall_deadband_count;
  logic                        clk_sel;
  // ==========================================================================
  // axi4-lite slave
  logic                        aw_held;
  logic                        w_held;
  logic [dbw_pkg::ADDR_W-1:0]  wr_addr;
  logic [dbw_pkg::DATA_W-1:0]  wr_data;
  logic                        wr_lane0;
  logic [dbw_pkg::DATA_W-1:0]  rd_mux;
  wire aw_fire = i_s_awvalid & o_s_awready;
  wire w_fire  = i_s_wvalid & o_s_wready;
  wire ar_fire = i_s_arvalid & o_s_arready;
  wire wr_go   = aw_held & w_held & ~o_s_bvalid;
  wire wr_en   = wr_go & wr_lane0;
  wire wr_ctrl  = wr_en & (wr_addr == dbw_pkg::OFF_CTRL);
  wire wr_shut  = wr_en & (wr_addr == dbw_pkg::OFF_SHUT);
  wire wr_fault = wr_en & (wr_addr == dbw_pkg::OFF_FAULT);
  wire wr_rise  = wr_en & (wr_addr == dbw_pkg::OFF_RISE);
  wire wr_fall  = wr_en & (wr_addr == dbw_pkg::OFF_FALL);
  wire wr_clk   = wr_en & (wr_addr == dbw_pkg::OFF_CLK);
  wire wr_map   = (wr_addr == dbw_pkg::OFF_CTRL) | (wr_addr == dbw_pkg::OFF_SHUT) |
                  (wr_addr == dbw_pkg::OFF_FAULT) | (wr_addr == dbw_pkg::OFF_RISE) |
                  (wr_addr == dbw_pkg::OFF_FALL) | (wr_addr == dbw_pkg::OFF_CLK) |
                  (wr_addr == dbw_pkg::OFF_STAT);
  wire rd_map   = (i_s_araddr == dbw_pkg::OFF_CTRL) | (i_s_araddr == dbw_pkg::OFF_SHUT) |
                  (i_s_araddr == dbw_pkg::OFF_FAULT) | (i_s_araddr == dbw_pkg::OFF_RISE) |
                  (i_s_araddr == dbw_pkg::OFF_FALL) | (i_s_araddr == dbw_pkg::OFF_CLK) |
                  (i_s_araddr == dbw_pkg::OFF_STAT);

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_s_awready <= 1'b1;
      o_s_wready  <= 1'b1;
      aw_held     <= 1'b0;
      w_held      <= 1'b0;
      wr_addr     <= '0;
      wr_data     <= '0;
      wr_lane0    <= 1'b0;
      o_s_bvalid  <= 1'b0;
      o_s_bresp   <= dbw_pkg::RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_held     <= 1'b1;
        wr_addr     <= i_s_awaddr;
        o_s_awready <= 1'b0;
      end
      if (w_fire) begin
        w_held     <= 1'b1;
        wr_data    <= i_s_wdata;
        wr_lane0   <= i_s_wstrb[0];
        o_s_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_held    <= 1'b0;
        w_held     <= 1'b0;
        o_s_bvalid <= 1'b1;
        o_s_bresp  <= wr_map ? dbw_pkg::RESP_OKAY : dbw_pkg::RESP_SLVERR;
      end
      if (o_s_bvalid && i_s_bready) begin
        o_s_bvalid  <= 1'b0;
        o_s_awready <= 1'b1;
        o_s_wready  <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // input synchronisers
  logic [dbw_pkg::SYNC_W-1:0] sync1;
  logic [dbw_pkg::SYNC_W-1:0] sync2;
  logic [dbw_pkg::SYNC_W-1:0] sync3;
  logic [dbw_pkg::SYNC_W-1:0] sync_lvl;
  // three stages, change once 2nd and 3rd agree
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      sync1    <= dbw_pkg::SYNC_RST;
      sync2    <= dbw_pkg::SYNC_RST;
      sync3    <= dbw_pkg::SYNC_RST;
      sync_lvl <= dbw_pkg::SYNC_RST;
    end else begin
      sync1    <= {i_fast_osc, i_fault_b, i_data};
      sync2    <= sync1;
      sync3    <= sync2;
      sync_lvl <= (sync2 & sync3) | (sync_lvl & (sync2 | sync3));
    end
  end
  logic data_d;
  logic osc_d;
  wire  data_s    = sync_lvl[0];
  wire  osc_s     = sync_lvl[dbw_pkg::SYNC_W-1];
  wire  [dbw_pkg::FAULT_N-1:0] fault_lvl_b = sync_lvl[dbw_pkg::FAULT_N:1];
  wire  data_rise = en & data_s & ~data_d;
  wire  data_fall = en & ~data_s & data_d;
  // select dead-band clock: fast oscillator edges or every system cycle
  wire  tick      = clk_sel ? (osc_s & ~osc_d) : 1'b1;
  wire  fault_act = |(~fault_lvl_b & fault_source_enable);
  // direct path from pins to the output flops, no software delay
  wire  fault_fast = |(~i_fault_b & fault_source_enable);

  // ==========================================================================
  // control registers
  wire en_set  = wr_ctrl & wr_data[dbw_pkg::EN_BIT] & ~en;
  logic ld_fall_seen;
  // active copy loads at rise after first fall once requested
  wire ld_take = en & load_request & ld_fall_seen & data_rise;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      en                  <= 1'b0;
      mode                <= '0;
      restart_en          <= 1'b0;
      override_level_bd   <= dbw_pkg::OVR_RST;
      override_level_ac   <= dbw_pkg::OVR_RST;
      fault_source_enable <= '0;
      rise_buf            <= '0;
      fall_buf            <= '0;
      clk_sel             <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        en   <= wr_data[dbw_pkg::EN_BIT];
        mode <= wr_data[dbw_pkg::MODE_LSB +: dbw_pkg::MODE_W];
      end
      if (wr_shut) begin
        restart_en        <= wr_data[dbw_pkg::REN_BIT];
        override_level_bd <= wr_data[dbw_pkg::OVR_BD_LSB +: 2];
        override_level_ac <= wr_data[dbw_pkg::OVR_AC_LSB +: 2];
      end
      if (wr_fault) fault_source_enable <= wr_data[dbw_pkg::FAULT_N-1:0];
      if (wr_rise)  rise_buf <= wr_data[dbw_pkg::CNT_W-1:0];
      if (wr_fall)  fall_buf <= wr_data[dbw_pkg::CNT_W-1:0];
      if (wr_clk)   clk_sel  <= wr_data[dbw_pkg::CS_BIT];
    end
  end

  // disabled writes load at once; enabled wait for request
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      rise_deadband_count <= '0;
      fall_deadband_count <= '0;
      load_request        <= 1'b0;
      ld_fall_seen        <= 1'b0;
    end else begin
      if (wr_rise && !en) rise_deadband_count <= wr_data[dbw_pkg::CNT_W-1:0];
      if (wr_fall && !en) fall_deadband_count <= wr_data[dbw_pkg::CNT_W-1:0];
      if (ld_take) begin
        rise_deadband_count <= rise_buf;
        fall_deadband_count <= fall_buf;
      end
      // request only honoured when already enabled
      if (wr_ctrl && en && wr_data[dbw_pkg::LD_BIT]) load_request <= 1'b1;
      else if (ld_take || !en) load_request <= 1'b0;
      if (!load_request || ld_take) ld_fall_seen <= 1'b0;
      else if (data_fall) ld_fall_seen <= 1'b1;
    end
  end

  // ==========================================================================
  // dead-band counters
  wire half     = en & (mode == dbw_pkg::MODE_HALF);
  wire fwd      = en & (mode == dbw_pkg::MODE_FWD);
  wire rev      = en & (mode == dbw_pkg::MODE_REV);
  wire full     = fwd | rev;
  logic cur_rev;
  // reverse band only on forward-to-reverse change
  wire to_rev   = data_rise & rev & ~cur_rev;
  // forward band only on reverse-to-forward change
  wire to_fwd   = data_rise & fwd & cur_rev;
  wire dir_chg  = to_rev | to_fwd;
  // band starts at the data edge itself
  wire rise_start  = (half & data_rise) | to_rev;
  wire fall_start  = (half & data_fall) | to_fwd;
  // reversal of the input cancels the waiting band
  wire rise_cancel = data_fall;
  wire fall_cancel = half ? data_rise : data_fall;
  logic                      rise_busy;
  logic                      fall_busy;
  logic [dbw_pkg::CNT_W-1:0] rise_cnt;
  logic [dbw_pkg::CNT_W-1:0] fall_cnt;
  wire [dbw_pkg::CNT_W-1:0] rise_inc = dbw_pkg::CNT_W'(rise_cnt + dbw_pkg::CNT_ONE);
  wire [dbw_pkg::CNT_W-1:0] fall_inc = dbw_pkg::CNT_W'(fall_cnt + dbw_pkg::CNT_ONE);
  // rise interval from the rise setting
  wire rise_hit  = rise_busy & tick & (rise_inc == rise_deadband_count) & ~rise_cancel;
  wire fall_hit  = fall_busy & tick & (fall_inc == fall_deadband_count) & ~fall_cancel;
  wire rise_done = (rise_start & (rise_deadband_count == dbw_pkg::CNT_ZERO)) | rise_hit;
  wire fall_done = (fall_start & (fall_deadband_count == dbw_pkg::CNT_ZERO)) | fall_hit;

  // count up from zero; unsynchronised edge removes at most one period
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || !en) begin
      rise_busy <= 1'b0;
      rise_cnt  <= '0;
    end else if (rise_cancel || rise_hit) begin
      rise_busy <= 1'b0;
    end else if (rise_start && !rise_done) begin
      rise_busy <= 1'b1;
      rise_cnt  <= '0;
    end else if (rise_busy && tick) begin
      rise_cnt  <= rise_inc;
    end
  end
  // same scheme for the falling band
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || !en) begin
      fall_busy <= 1'b0;
      fall_cnt  <= '0;
    end else if (fall_cancel || fall_hit) begin
      fall_busy <= 1'b0;
    end else if (fall_start && !fall_done) begin
      fall_busy <= 1'b1;
      fall_cnt  <= '0;
    end else if (fall_busy && tick) begin
      fall_cnt  <= fall_inc;
    end
  end

  // ==========================================================================
  // waveform levels
  logic lvl_p;
  logic lvl_n;
  // half bridge out_a rises only when the rise band completes
  wire set_p  = rise_done | (full & (fall_done | (data_rise & ~dir_chg)));
  // half bridge out_b rises when the fall band completes
  wire set_n  = half & fall_done;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      lvl_p   <= 1'b0;
      lvl_n   <= 1'b0;
      cur_rev <= 1'b0;
      data_d  <= 1'b0;
      osc_d   <= 1'b0;
    end else begin
      data_d  <= data_s;
      osc_d   <= osc_s;
      lvl_p   <= (data_fall | (data_rise & ~set_p)) ? 1'b0 : (set_p ? 1'b1 : lvl_p);
      lvl_n   <= (data_rise | (data_fall & ~set_n)) ? 1'b0 : (set_n ? 1'b1 : lvl_n);
      if (data_rise) cur_rev <= rev;
    end
  end
  // full bridge: a/c static by direction, b or d modulated
  wire wave_a = half ? lvl_p : (full & ~cur_rev);
  wire wave_b = half ? lvl_n : (full & cur_rev & lvl_p);
  wire wave_c = half ? lvl_p : (full & cur_rev);
  wire wave_d = half ? lvl_n : (full & ~cur_rev & lvl_p);

  // ==========================================================================
  // shutdown
  logic resume_hold;
  // software set forces shutdown; enabling starts in shutdown
  wire sd_set   = fault_act | en_set | (wr_shut & wr_data[dbw_pkg::SD_BIT]);
  // software clear loses to any live condition
  wire sd_clr   = wr_shut & ~wr_data[dbw_pkg::SD_BIT];
  // auto restart clears the bit itself
  wire sd_auto  = restart_en & shutdown;
  // clearing only possible with no source present
  wire next_shutdown = sd_set | (shutdown & ~sd_auto & ~sd_clr);
  wire force_ovr = shutdown | resume_hold | fault_fast;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      shutdown         <= 1'b0;
      resume_hold      <= 1'b0;
      o_shutdown_event <= 1'b0;
      o_fast_osc_keep  <= 1'b0;
    end else begin
      shutdown         <= next_shutdown;
      // stay overridden until the first data rise after clearing
      resume_hold      <= shutdown | (resume_hold & ~data_rise);
      // pulse whenever the bit becomes set
      o_shutdown_event <= next_shutdown & ~shutdown;
      // keep the fast oscillator alive while it times the bands
      o_fast_osc_keep  <= en & clk_sel;
    end
  end
  // bd field for b/d, ac field for a/c
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_out_a <= 1'b0;
      o_out_b <= 1'b0;
      o_out_c <= 1'b0;
      o_out_d <= 1'b0;
    end else begin
      o_out_a <= en & (force_ovr ? override_level_ac[dbw_pkg::OVR_HI_BIT] : wave_a);
      o_out_b <= en & (force_ovr ? override_level_bd[dbw_pkg::OVR_HI_BIT] : wave_b);
      o_out_c <= en & (force_ovr ? override_level_ac[dbw_pkg::OVR_HI_BIT] : wave_c);
      o_out_d <= en & (force_ovr ? override_level_bd[dbw_pkg::OVR_HI_BIT] : wave_d);
    end
  end

  // ==========================================================================
  // register read
  assign rd_mux = (i_s_araddr == dbw_pkg::OFF_CTRL)  ? {24'h0, en, load_request, 3'h0, mode} :
                  (i_s_araddr == dbw_pkg::OFF_SHUT)  ? {24'h0, shutdown, restart_en, override_level_bd,
                                                        override_level_ac, 2'h0} :
                  (i_s_araddr == dbw_pkg::OFF_FAULT) ? {28'h0, fault_source_enable} :
                  (i_s_araddr == dbw_pkg::OFF_RISE)  ? {26'h0, rise_buf} :
                  (i_s_araddr == dbw_pkg::OFF_FALL)  ? {26'h0, fall_buf} :
                  (i_s_araddr == dbw_pkg::OFF_CLK)   ? {31'h0, clk_sel} :
                  (i_s_araddr == dbw_pkg::OFF_STAT)  ? {18'h0, fall_deadband_count, rise_deadband_count,
                                                        fault_act, data_s} : 32'h0;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_s_arready <= 1'b1;
      o_s_rvalid  <= 1'b0;
      o_s_rdata   <= '0;
      o_s_rresp   <= dbw_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      o_s_arready <= 1'b0;
      o_s_rvalid  <= 1'b1;
      o_s_rdata   <= rd_mux;
      o_s_rresp   <= rd_map ? dbw_pkg::RESP_OKAY : dbw_pkg::RESP_SLVERR;
    end else if (o_s_rvalid && i_s_rready) begin
      o_s_arready <= 1'b1;
      o_s_rvalid  <= 1'b0;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  sequence s_hb_rise;
    half && data_rise && !shutdown;
  endsequence
  sequence s_sd_clear;
    shutdown ##1 !shutdown;
  endsequence

  rise_hold_a: assert property (s_hb_rise ##0 (rise_deadband_count != dbw_pkg::CNT_ZERO) |=> !lvl_p)
    else $error("out_a rose before its dead band");
  zero_band_a: assert property (s_hb_rise ##0 (rise_deadband_count == dbw_pkg::CNT_ZERO) |=> lvl_p)
    else $error("zero rise band still delayed out_a");
  pulse_suppress_a: assert property (rise_busy && data_fall |=> !lvl_p && !rise_busy)
    else $error("reversed input did not suppress pulse");
  band_count_a: assert property (rise_busy && tick && !rise_hit && !rise_cancel
                                 |=> rise_cnt == $past(rise_inc))
    else $error("dead band counter did not step");
  fault_force_a: assert property (en && fault_fast |=> o_out_a == $past(override_level_ac[dbw_pkg::OVR_HI_BIT])
                                  && o_out_d == $past(override_level_bd[dbw_pkg::OVR_HI_BIT]))
    else $error("fault did not force override levels");
  fault_hold_a: assert property (fault_act |=> shutdown [*2] or (shutdown ##1 !$past(fault_act)))
    else $error("shutdown cleared under fault");
  clear_ignored_a: assert property (sd_clr && fault_act |=> shutdown)
    else $error("software cleared shutdown under fault");
  event_flag_a: assert property ($rose(shutdown) |-> o_shutdown_event)
    else $error("no event on shutdown set");
  auto_restart_a: assert property (shutdown && restart_en && !sd_set |=> !shutdown)
    else $error("auto restart did not clear shutdown");
  resume_wait_a: assert property (s_sd_clear ##0 !data_rise |=> force_ovr)
    else $error("outputs resumed before data rise");
  load_now_a: assert property (wr_rise && !en |=> rise_deadband_count == $past(wr_data[dbw_pkg::CNT_W-1:0]))
    else $error("disabled write did not load active count");
endmodule

/* File: bench/dbw_pwm_src.sv */
// pwm source model driving the data input of the bridge block
module dbw_pwm_src #(
  parameter int HI = 30,
  parameter int LO = 30
) (
  // clock and run control
  input  wire logic i_mclk,
  input  wire logic i_run,
  // data toward the block
  output logic      o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // free-running period; held low while stopped
  always @(posedge i_mclk) begin
    cnt <= (cnt >= HI + LO - 1) ? 0 : cnt + 1;
    o_data <= i_run && (cnt < HI);
  end
endmodule

/* File: bench/tb.sv */
// self-checking bench for the dead-band and shutdown block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst_b = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, run = 0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wd = 32'h0, rd;
  logic [3:0]  flt = 4'hf;
  logic        awr, wrd, bv, arr, rv, dat, oa, ob, oc, od, ev, fk;
  logic [1:0]  fo = 2'h0;
  logic [1:0]  br, rr;
  int          error_cnt = 0, n_tests = 0, ev_cnt = 0;
  always #5 clk = ~clk;
  // fast oscillator stand-in: one rising edge every four clocks
  always @(posedge clk) fo <= fo + 2'h1;
  always @(posedge clk) if (ev === 1'b1) ev_cnt <= ev_cnt + 1;
  dbw_pwm_src src (.i_mclk(clk), .i_run(run), .o_data(dat));
  dbw_top uut (.i_mclk(clk), .i_rst_b(rst_b), .i_s_awvalid(awv), .o_s_awready(awr), .i_s_awaddr(adr),
    .i_s_awprot(3'h0), .i_s_wvalid(wv), .o_s_wready(wrd), .i_s_wdata(wd), .i_s_wstrb(4'hf),
    .o_s_bvalid(bv), .i_s_bready(bry), .o_s_bresp(br), .i_s_arvalid(arv), .o_s_arready(arr),
    .i_s_araddr(adr), .i_s_arprot(3'h0), .o_s_rvalid(rv), .i_s_rready(rry), .o_s_rdata(rd),
    .o_s_rresp(rr), .i_data(dat), .i_fault_b(flt), .i_fast_osc(fo[1]), .o_out_a(oa), .o_out_b(ob),
    .o_out_c(oc), .o_out_d(od), .o_shutdown_event(ev), .o_fast_osc_keep(fk));
  task finish_test;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // a used-up wait ends the run
  task lim(input int k);
    if (k >= 300) begin
      error_cnt++;
      finish_test;
    end
  endtask
  // one write (w=1) or read; read data expected in d
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int k;
    @(posedge clk);
    adr <= a;
    wd <= d;
    awv <= w;
    wv <= w;
    bry <= w;
    arv <= !w;
    rry <= !w;
    for (k = 0; k < 300; k++) begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (arr) arv <= 1'b0;
      if ((bv && bry) || (rv && rry)) break;
    end
    lim(k);
    bry <= 1'b0;
    rry <= 1'b0;
    check(w ? br : rr, e);
    if (!w) check(rd, d);
  endtask
  // p=1: delay from data rise to out_a on; p=0: fall to out_b on
  task band(input logic p, input int n);
    int k;
    for (k = 0; k < 300 && dat !== !p; k++) @(posedge clk);
    lim(k);
    for (k = 0; k < 300 && dat !== p; k++) @(posedge clk);
    lim(k);
    for (k = 0; k < 300 && (p ? oa : ob) !== 1'b1; k++) @(posedge clk);
    lim(k);
    check(k >= n, 32'h1);
    check(k <= n + 8, 32'h1);
    check(p ? ob : oa, 32'h0);
  endtask
  task shut(input logic [31:0] v);
    bus(0, dbw_pkg::OFF_SHUT, v, dbw_pkg::RESP_OKAY);
  endtask
  task put(input logic [7:0] a, input logic [31:0] v);
    bus(1, a, v, dbw_pkg::RESP_OKAY);
  endtask
  // full bridge, r=1 reverse: mode written early in a low phase, delay of modulated output after the rise
  task bridge(input logic r, input int n);
    int k;
    for (k = 0; k < 300 && dat !== 1'b1; k++) @(posedge clk);
    lim(k);
    for (k = 0; k < 300 && dat !== 1'b0; k++) @(posedge clk);
    lim(k);
    put(dbw_pkg::OFF_CTRL, r ? 32'h83 : 32'h82);
    for (k = 0; k < 300 && dat !== 1'b1; k++) @(posedge clk);
    lim(k);
    for (k = 0; k < 300 && (r ? ob : od) !== 1'b1; k++) @(posedge clk);
    lim(k);
    check(k >= n && k <= n + 8, 32'h1);
    check({oa, oc, r ? od : ob}, r ? 32'h2 : 32'h4);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    check({oa, ob, oc, od}, 32'h0);
    shut(32'h14);
    bus(1, 8'h40, 32'h1, dbw_pkg::RESP_SLVERR);
    bus(0, 8'h40, 32'h0, dbw_pkg::RESP_SLVERR);
    put(dbw_pkg::OFF_SHUT, 32'h20);
    put(dbw_pkg::OFF_RISE, 32'h3);
    put(dbw_pkg::OFF_FALL, 32'h5);
    put(dbw_pkg::OFF_FAULT, 32'h1);
    bus(0, dbw_pkg::OFF_RISE, 32'h3, dbw_pkg::RESP_OKAY);
    run <= 1'b1;
    put(dbw_pkg::OFF_CTRL, 32'hc4);
    bus(0, dbw_pkg::OFF_CTRL, 32'h84, dbw_pkg::RESP_OKAY);
    repeat (10) @(posedge clk);
    check(ev_cnt, 32'h1);
    check({oa, ob, oc, od}, 32'h5);
    shut(32'ha0);
    put(dbw_pkg::OFF_SHUT, 32'h20);
    band(1, 3);
    band(0, 5);
    flt <= 4'he;
    repeat (2) @(posedge clk);
    check({oa, ob, oc, od}, 32'h5);
    repeat (6) @(posedge clk);
    put(dbw_pkg::OFF_SHUT, 32'h20);
    shut(32'ha0);
    check(ev_cnt, 32'h2);
    flt <= 4'hf;
    repeat (10) @(posedge clk);
    put(dbw_pkg::OFF_SHUT, 32'h20);
    shut(32'h20);
    band(1, 3);
    put(dbw_pkg::OFF_SHUT, 32'ha0);
    repeat (80) @(posedge clk);
    check({oa, ob, oc, od}, 32'h5);
    shut(32'ha0);
    put(dbw_pkg::OFF_SHUT, 32'he0);
    shut(32'h60);
    band(1, 3);
    flt <= 4'he;
    repeat (10) @(posedge clk);
    check({oa, ob, oc, od}, 32'h5);
    flt <= 4'hf;
    repeat (10) @(posedge clk);
    shut(32'h60);
    check(ev_cnt, 32'h4);
    band(1, 3);
    put(dbw_pkg::OFF_RISE, 32'h6);
    band(1, 3);
    put(dbw_pkg::OFF_CTRL, 32'hc4);
    band(0, 5);
    band(1, 6);
    bus(0, dbw_pkg::OFF_CTRL, 32'h84, dbw_pkg::RESP_OKAY);
    bridge(0, 0);
    bridge(1, 6);
    bridge(0, 5);
    put(dbw_pkg::OFF_CTRL, 32'h84);
    check(fk, 32'h0);
    put(dbw_pkg::OFF_CLK, 32'h1);
    bus(0, dbw_pkg::OFF_CLK, 32'h1, dbw_pkg::RESP_OKAY);
    band(1, 24);
    check(fk, 32'h1);
    finish_test;
  end
endmodule
